// file: hdl/power_save_defines.svh
// Constants of the power-save sequencer
`ifndef POWER_SAVE_DEFINES_SVH
`define POWER_SAVE_DEFINES_SVH
`define CMD_SPD_TOGGLE 8'ha2
`define CMD_WAKEUP 8'ha7
`define CMD_SHUTDOWN 8'ha8
`define SPD_EN_RESET 1'b1
`define IDLE_CYCLES_DEFAULT 32'd100000
`endif

// file: hdl/power_save_pkg.sv
// Types of the power-save sequencer
package power_save_pkg;
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_IDLE_SLEEP = 3'b001,
		ST_CMD_SLEEP = 3'b010,
		ST_PIN_SLEEP = 3'b011,
		ST_FLUSH = 3'b100
	} ps_state_t;
endpackage

// file: hdl/touch_controller_power_save.sv
// Power-save sequencer of the touch controller
//
// Contract
// RULE1: Toggle self-power-down enable on each received toggle command byte; the code toggles only in ST_RUN with the shutdown pin high.
// RULE2: With self-power-down enabled, sleep once touch and UART are both idle.
// RULE3: With self-power-down enabled, wake from idle sleep on touch or UART traffic.
// RULE4: In standby, halt all activity and stop the oscillator.
// RULE5: Drive the LED output high throughout standby.
// RULE6: Host waits 1 ms or 3 ms after wakeup before sending commands; host_model waits 10 clock cycles (1 us) instead.
// RULE7: Standby while shutdown pin low, until pin high or released.
// RULE8: While shutdown pin low, ignore every touch and UART byte.
// RULE9: On shutdown pin release, clear UART buffers then resume.
// RULE10: Shutdown command byte puts the device into standby.
// RULE11: Command standby with self-power-down enabled wakes on wakeup byte or touch.
// RULE12: Command standby with self-power-down disabled wakes only on wakeup byte.
// RULE13: Waking from command standby clears UART buffers before resuming.
// RULE14: Self-power-down is enabled after reset.
// RULE15: No reply byte is sent for the wakeup command.
// RULE16: Host sends wakeup before other commands when self-power-down enabled; tb sends the shutdown and toggle bytes with it enabled and no wakeup first.
// RULE17: Idle counter, cleared by touch or UART activity, judges inactivity.
`timescale 1ns/10ps
`include "power_save_defines.svh"

module touch_controller_power_save #(
	parameter int IDLE_CYCLES = `IDLE_CYCLES_DEFAULT,
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Shutdown pin, active low
	input wire logic shutdown_n,
	// Activity sources
	input wire logic touch_detect,
	input wire logic uart_activity,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	// Standby and housekeeping outputs
	output logic standby,
	output logic osc_enable,
	output logic led,
	output logic uart_flush,
	output logic core_enable,
	output logic spd_enable,
	output power_save_pkg::ps_state_t state
);
	import power_save_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Command decode and activity
	logic byte_cmd_toggle;
	logic byte_cmd_wake;
	logic byte_cmd_shut;
	logic active;

	// State group
	ps_state_t state_r;
	ps_state_t state_nxt;

	// Self-power-down enable group
	logic spd_r;
	logic spd_nxt;

	// Idle counter group
	logic [CNT_W-1:0] idle_r;
	logic [CNT_W-1:0] idle_nxt;
	logic idle_done;

	// Output register group
	logic standby_r;
	logic standby_nxt;
	logic led_r;
	logic led_nxt;
	logic osc_r;
	logic osc_nxt;
	logic core_r;
	logic core_nxt;
	logic flush_r;
	logic flush_nxt;

	////////////////////////////////////////////////////////////////////////
	// Received byte matches a command code
	function automatic logic is_cmd(input logic v, input logic [7:0] b, input logic [7:0] c);
		is_cmd = v && (b == c);
	endfunction

	// Any of the three standby states
	function automatic logic is_sleep(input ps_state_t s);
		case (s)
			ST_IDLE_SLEEP: begin
				is_sleep = 1'b1;
			end
			ST_CMD_SLEEP: begin
				is_sleep = 1'b1;
			end
			ST_PIN_SLEEP: begin
				is_sleep = 1'b1;
			end
			default: begin
				is_sleep = 1'b0;
			end
		endcase
	endfunction

	assign byte_cmd_toggle = is_cmd(rx_valid, rx_byte, `CMD_SPD_TOGGLE);
	assign byte_cmd_wake = is_cmd(rx_valid, rx_byte, `CMD_WAKEUP);
	assign byte_cmd_shut = is_cmd(rx_valid, rx_byte, `CMD_SHUTDOWN);
	// Bytes count as traffic too, so a command stream keeps the block awake
	assign active = touch_detect || uart_activity || rx_valid;
	// Idle time is used up only while self-power-down is on
	assign idle_done = spd_r && (idle_r >= CNT_W'(IDLE_CYCLES - 1)); // [RULE2]

	////////////////////////////////////////////////////////////////////////
	// Next state; the shutdown pin overrides every other cause
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (!shutdown_n) begin
					state_nxt = ST_PIN_SLEEP; // [RULE7]
				end else if (byte_cmd_shut) begin
					state_nxt = ST_CMD_SLEEP; // [RULE10]
				end else if (!active && idle_done) begin
					state_nxt = ST_IDLE_SLEEP; // [RULE2]
				end
				// A wakeup byte while running only counts as traffic, with no reply [RULE15]
			end
			ST_IDLE_SLEEP: begin
				if (!shutdown_n) begin
					state_nxt = ST_PIN_SLEEP; // [RULE7]
				end else if (active) begin
					state_nxt = ST_RUN; // [RULE3]
				end
			end
			ST_CMD_SLEEP: begin
				if (!shutdown_n) begin
					state_nxt = ST_PIN_SLEEP; // [RULE7]
				end else if (byte_cmd_wake) begin
					state_nxt = ST_FLUSH; // [RULE11] [RULE12]
				end else if (spd_r && touch_detect) begin
					state_nxt = ST_FLUSH; // [RULE11]
				end
			end
			ST_PIN_SLEEP: begin
				// Touches and bytes are not looked at here [RULE8]
				if (shutdown_n) begin
					state_nxt = ST_FLUSH; // [RULE9]
				end
			end
			ST_FLUSH: begin
				if (!shutdown_n) begin
					state_nxt = ST_PIN_SLEEP; // [RULE7]
				end else begin
					state_nxt = ST_RUN; // [RULE9] [RULE13]
				end
			end
			default: begin
				state_nxt = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Toggle byte acts only while running and not overridden
	always_comb begin
		spd_nxt = spd_r;
		if ((state_r == ST_RUN) && shutdown_n && !byte_cmd_shut && byte_cmd_toggle) begin
			spd_nxt = !spd_r; // [RULE1]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			spd_r <= `SPD_EN_RESET; // [RULE14]
		end else begin
			spd_r <= spd_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counts consecutive quiet cycles in run; cleared on activity or leaving run
	always_comb begin
		idle_nxt = '0;
		if ((state_r == ST_RUN) && (state_nxt == ST_RUN) && !active) begin
			idle_nxt = idle_r + CNT_W'(1); // [RULE17]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_r <= '0;
		end else begin
			idle_r <= idle_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs follow the next state so that they line up with state_r
	always_comb begin
		standby_nxt = is_sleep(state_nxt);
		led_nxt = is_sleep(state_nxt); // [RULE5]
		osc_nxt = !is_sleep(state_nxt); // [RULE4]
		// The core is held off in the flush cycle while the buffers clear
		core_nxt = !is_sleep(state_nxt) && (state_nxt != ST_FLUSH); // [RULE4] [RULE8] [RULE13]
		flush_nxt = (state_nxt == ST_FLUSH); // [RULE9] [RULE13]
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			standby_r <= 1'b0;
			led_r <= 1'b0;
			osc_r <= 1'b1;
			core_r <= 1'b1;
			flush_r <= 1'b0;
		end else begin
			standby_r <= standby_nxt;
			led_r <= led_nxt;
			osc_r <= osc_nxt;
			core_r <= core_nxt;
			flush_r <= flush_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Every output is a flip-flop
	assign standby = standby_r;
	assign led = led_r;
	assign osc_enable = osc_r;
	assign core_enable = core_r;
	assign uart_flush = flush_r;
	assign spd_enable = spd_r;
	assign state = state_r;
endmodule

// file: testbench/host_model.sv
// Host driver model sending command bytes
`timescale 1ns/10ps
module host_model (input wire logic ref_clk, output logic rx_valid, output logic [7:0] rx_byte);
	logic [7:0] last = 8'h00;
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end
	task send(input logic [7:0] b);
		if (last == 8'ha7) repeat (10) @(negedge ref_clk);
		@(negedge ref_clk);
		rx_valid = 1'b1;
		rx_byte = b;
		last = b;
		@(negedge ref_clk);
		rx_valid = 1'b0;
		rx_byte = ~b;
	endtask
endmodule

// file: testbench/ps_checker.sv
// Port assertions of the power-save sequencer
`timescale 1ns/10ps
module ps_checker (input wire logic ref_clk, rst_n, shutdown_n, touch_detect, uart_activity, rx_valid,
	input wire logic [7:0] rx_byte, input wire logic standby, osc_enable, led, uart_flush, core_enable, spd_enable,
	input wire power_save_pkg::ps_state_t state);
	import power_save_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	led_std_a: assert property (led == standby) else $error("led differs from standby");
	osc_stop_a: assert property (osc_enable != standby) else $error("oscillator runs in standby");
	pin_in_a: assert property (!shutdown_n |=> state == ST_PIN_SLEEP) else $error("no pin sleep");
	pin_out_a: assert property (state == ST_PIN_SLEEP && shutdown_n |=> uart_flush ##1 !uart_flush && core_enable)
		else $error("pin exit without one flush");
	cmd_in_a: assert property (state == ST_RUN && shutdown_n && rx_valid && rx_byte == 8'ha8 |=> standby)
		else $error("shutdown byte ignored");
	cmd_wake_a: assert property (state == ST_CMD_SLEEP && shutdown_n && rx_valid && rx_byte == 8'ha7
		|=> uart_flush && !standby) else $error("wakeup byte missed");
	touch_ign_a: assert property (state == ST_CMD_SLEEP && shutdown_n && !spd_enable && !rx_valid |=> standby)
		else $error("woke without wakeup byte");
	tgl_a: assert property (state == ST_RUN && shutdown_n && rx_valid && rx_byte == 8'ha2
		|=> spd_enable != $past(spd_enable)) else $error("toggle byte ignored");
endmodule
bind touch_controller_power_save ps_checker chk (.*);

// file: testbench/tb.sv
// Self-checking bench of the power-save sequencer
`timescale 1ns/10ps
module tb;
	logic ref_clk = 0, rst_n = 0, sd_n = 1, td = 0, ua = 1, rv, sb, oe, led, fl, ce, spd;
	logic [7:0] rb;
	power_save_pkg::ps_state_t st;
	int miscompares = 0, samples_checked = 0;
	always #50 ref_clk = ~ref_clk;
	host_model h (.ref_clk(ref_clk), .rx_valid(rv), .rx_byte(rb));
	touch_controller_power_save #(.IDLE_CYCLES(8)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .shutdown_n(sd_n),
		.touch_detect(td), .uart_activity(ua), .rx_valid(rv), .rx_byte(rb), .standby(sb), .osc_enable(oe),
		.led(led), .uart_flush(fl), .core_enable(ce), .spd_enable(spd), .state(st));
	task chk(input string n, input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task cmd_touch;
		ua = 0;
		h.send(8'ha8);
		chk("led", led, 1);
		chk("osc", oe, 0);
		td = 1;
		@(negedge ref_clk);
		chk("flush", fl, 1);
		chk("core", ce, 0);
		td = 0;
		ua = 1;
		@(negedge ref_clk);
		chk("core", ce, 1);
	endtask
	task cmd_nospd;
		h.send(8'ha2);
		chk("spd", spd, 0);
		ua = 0;
		h.send(8'ha8);
		td = 1;
		repeat (3) @(negedge ref_clk);
		chk("standby", sb, 1);
		td = 0;
		h.send(8'ha7);
		ua = 1;
		chk("standby", sb, 0);
		h.send(8'ha2);
	endtask
	task pin_idle;
		sd_n = 0;
		@(negedge ref_clk);
		h.send(8'ha7);
		chk("state", st, 3);
		sd_n = 1;
		@(negedge ref_clk);
		chk("flush", fl, 1);
		ua = 0;
		repeat (10) @(negedge ref_clk);
		chk("state", st, 1);
		ua = 1;
		@(negedge ref_clk);
		chk("standby", sb, 0);
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		rst_n = 1;
		chk("spd", spd, 1);
		cmd_touch();
		cmd_nospd();
		pin_idle();
		close_out();
	end
	initial begin
		repeat (2000) @(posedge ref_clk);
		miscompares++;
		close_out();
	end
endmodule
